// file: core/sarsr_device.sv
// converter end: samples the link pins and shifts the result frame out
`timescale 1ns/1ps
module sarsr_device
  import sarsr_pkg::*;
#(
  parameter int RES_BITS = 12
) (
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                reset,
  // link pins
  sarsr_if.device                  link,
  // analog sample, already two's complement
  input  wire logic [RES_BITS-1:0] sampleIn,
  // status
  output logic                     poweredDown,
  output logic                     trackMode,
  output logic                     readyValid
);
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_SHIFT = 4'b0010,
    ST_DONE  = 4'b0100,
    ST_SPARE = 4'b1000
  } sarsr_dev_state_t;

  // ****************************************
  // pin sampling
  // ****************************************
  logic csN;
  logic sclk;
  logic csN_q;
  logic sclk_q;
  sarsr_sync #(.INIT(1'b1)) uCs (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .pinIn    (link.chipSelectN),
    .levelOut (csN)
  );
  sarsr_sync #(.INIT(1'b0)) uSck (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .pinIn    (link.serialClock),
    .levelOut (sclk)
  );
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      csN_q  <= 1'b1;
      sclk_q <= 1'b0;
    end else begin
      csN_q  <= csN;
      sclk_q <= sclk;
    end
  end
  // pin to strobe costs two cycles, so a link half period must be longer
  wire csFall  = csN_q & ~csN;
  wire csRise  = ~csN_q & csN;
  wire sckFall = sclk_q & ~sclk & ~csN;
  wire sckRise = ~sclk_q & sclk & ~csN;

  // ****************************************
  // frame sequencer
  // ****************************************
  sarsr_dev_state_t state_q;
  logic [CNT_W-1:0] fallCnt_q;
  logic [FRAME_BITS-1:0] frame_q;
  logic outOeN_q;
  logic outBit_q;
  logic wasDown_q;
  // result laid out msb first after the leading zeros
  logic [FRAME_BITS-1:0] frameImage;
  always_comb begin
    frameImage = '0;
    frameImage[FRAME_BITS-1-LEAD_ZEROS -: RES_BITS] = sampleIn;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q   <= ST_IDLE;
      fallCnt_q <= 5'h00;
      frame_q   <= 16'h0000;
      outOeN_q  <= 1'b1;
      outBit_q  <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          outOeN_q <= 1'b1;
          if (csFall) begin
            frame_q   <= frameImage;
            fallCnt_q <= 5'h00;
            outOeN_q  <= 1'b0;
            outBit_q  <= 1'b0;
            state_q   <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (csRise) begin
            outOeN_q  <= 1'b1;
            state_q   <= ST_IDLE;
          end else if (sckFall) begin
            fallCnt_q <= fallCnt_q + 5'h01;
            if (fallCnt_q == 5'(FRAME_BITS - 1)) begin
              outOeN_q  <= 1'b1;
              state_q   <= ST_DONE;
            end else begin
              outBit_q <= frame_q[FRAME_BITS - 2 - fallCnt_q];
            end
          end
        end
        ST_DONE: begin
          // clocks after the sixteenth fall are ignored until select goes high
          outOeN_q <= 1'b1;
          if (csN) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          outOeN_q  <= 1'b1;
          state_q   <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // track and hold
  // ****************************************
  // hold from select fall until the rise that follows fall thirteen
  // select high outside a frame always tracks, so a cut frame never leaves the sample held
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      trackMode <= 1'b1;
    end else if (csFall) begin
      trackMode <= 1'b0;
    end else if (state_q == ST_SHIFT && sckRise && fallCnt_q >= 5'(HOLD_END_EDGE)) begin
      trackMode <= 1'b1;
    end else if (state_q != ST_SHIFT && csN) begin
      trackMode <= 1'b1;
    end
  end

  // ****************************************
  // power mode
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      poweredDown <= 1'b0;
      wasDown_q   <= 1'b0;
    end else if (csFall) begin
      wasDown_q <= poweredDown;
    end else if (state_q == ST_SHIFT && csRise) begin
      if (fallCnt_q >= 5'(AWAKE_MIN_EDGE)) begin
        poweredDown <= 1'b0;
      end else if (fallCnt_q >= 5'(SLEEP_MIN_EDGE)) begin
        poweredDown <= 1'b1;
      end else begin
        poweredDown <= wasDown_q;
      end
    end else if (state_q == ST_SHIFT && wasDown_q && sckFall && fallCnt_q == 5'(AWAKE_MIN_EDGE - 1)) begin
      // a dummy frame wakes at its tenth fall, before the rise decides anything
      poweredDown <= 1'b0;
    end
  end

  // analog settles within the power-up time after waking
  // readiness is status only; a frame started before it is not blocked
  logic [TIMER_W-1:0] wakeCnt_q;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wakeCnt_q <= TIMER_W'(POWERUP_CYC);
    end else if (poweredDown) begin
      wakeCnt_q <= TIMER_W'(POWERUP_CYC);
    end else if (wakeCnt_q != '0) begin
      wakeCnt_q <= wakeCnt_q - 8'h01;
    end
  end
  assign readyValid = ~poweredDown & (wakeCnt_q == '0);

  // a released output keeps its last bit; the host ignores the enable and takes bit sixteen after release
  assign link.serialResultOut = outBit_q;
  assign link.serialResultOeN = outOeN_q;
endmodule

// file: core/sarsr_pkg.sv
// shared constants for the serial converter readout link
package sarsr_pkg;
  // ****************************************
  // frame geometry
  // ****************************************
  localparam int FRAME_BITS      = 16;
  localparam int LEAD_ZEROS      = 4;
  localparam int HOLD_END_EDGE   = 13;
  localparam int SLEEP_MIN_EDGE  = 2;
  localparam int AWAKE_MIN_EDGE  = 10;
  localparam int FRAME_CLOCKS    = 18;
  localparam int CNT_W           = 5;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_PS   = 20000;
  localparam int QUIET_NS        = 60;
  localparam int ACQ_NS          = 290;
  localparam int POWERUP_NS      = 1000;
  localparam int QUIET_CYC       = (QUIET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ACQ_CYC         = (ACQ_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int POWERUP_CYC     = (POWERUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int SCLK_HALF_CYC   = 4;
  localparam int TIMER_W         = 8;
endpackage

// file: core/sarsr_if.sv
// pins between converter and its host controller
`timescale 1ns/1ps
interface sarsr_if;
  logic chipSelectN;
  logic serialClock;
  logic serialResultOut;
  logic serialResultOeN;
  modport device (input chipSelectN, input serialClock, output serialResultOut, output serialResultOeN);
  modport host (input serialResultOut, input serialResultOeN, output chipSelectN, output serialClock);
endinterface

// file: core/sarsr_sync.sv
// two flip-flop synchroniser for one pin
`timescale 1ns/1ps
module sarsr_sync #(
  parameter logic INIT = 1'b0
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // pin and synchronised level
  input  wire logic pinIn,
  output logic      levelOut
);
  logic stage1_q;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stage1_q <= INIT;
      levelOut <= INIT;
    end else begin
      stage1_q <= pinIn;
      levelOut <= stage1_q;
    end
  end
endmodule

// file: core/sarsr_host.sv
// host end: drives select and serial clock, collects the result frame
`timescale 1ns/1ps
module sarsr_host
  import sarsr_pkg::*;
#(
  parameter int RES_BITS = 12,
  parameter int HALF_CYC = SCLK_HALF_CYC
) (
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                reset,
  // link pins
  sarsr_if.host                    link,
  // user request: clocks is the falling edge count before select rises, capped at FRAME_CLOCKS
  input  wire logic                startReq,
  input  wire logic [CNT_W-1:0]    clocksReq,
  output logic                     busy,
  // result
  output logic [RES_BITS-1:0]      resultData,
  output logic                     resultValid
);
  typedef enum logic [3:0] {
    HS_IDLE  = 4'b0001,
    HS_RUN   = 4'b0010,
    HS_QUIET = 4'b0100,
    HS_SPARE = 4'b1000
  } sarsr_host_state_t;

  // ****************************************
  // input sampling
  // ****************************************
  logic sdo;
  sarsr_sync #(.INIT(1'b0)) uSdo (.ref_clk(ref_clk), .reset(reset), .pinIn(link.serialResultOut), .levelOut(sdo));

  sarsr_host_state_t state_q;
  logic [TIMER_W-1:0] div_q;
  logic [TIMER_W-1:0] gap_q;
  logic [CNT_W-1:0] fall_q;
  logic [CNT_W-1:0] target_q;
  logic [FRAME_BITS-1:0] shift_q;
  logic csN_q;
  logic sck_q;
  wire halfTick = (div_q == TIMER_W'(HALF_CYC - 1));

  // ****************************************
  // frame generator
  // ****************************************
  // capture on our rising edge, two cycles late through the synchroniser,
  // which works because the bit the device sets after a fall reaches sdo only after that rise
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q     <= HS_IDLE;
      div_q       <= 8'h00;
      gap_q       <= 8'h00;
      fall_q      <= 5'h00;
      target_q    <= 5'h00;
      shift_q     <= 16'h0000;
      csN_q       <= 1'b1;
      sck_q       <= 1'b0;
      resultData  <= '0;
      resultValid <= 1'b0;
    end else begin
      resultValid <= 1'b0;
      case (state_q)
        HS_IDLE: begin
          if (startReq) begin
            target_q <= (clocksReq > 5'(FRAME_CLOCKS)) ? 5'(FRAME_CLOCKS) : clocksReq;
            csN_q    <= 1'b0;
            sck_q    <= 1'b1;
            fall_q   <= 5'h00;
            div_q    <= 8'h00;
            state_q  <= HS_RUN;
          end
        end
        HS_RUN: begin
          div_q <= halfTick ? 8'h00 : div_q + 8'h01;
          if (halfTick) begin
            if (sck_q) begin
              if (fall_q == target_q) begin
                csN_q   <= 1'b1;
                gap_q   <= TIMER_W'(ACQ_CYC + QUIET_CYC);
                state_q <= HS_QUIET;
                if (fall_q >= 5'(FRAME_BITS)) begin
                  resultData  <= shift_q[FRAME_BITS-1-LEAD_ZEROS -: RES_BITS];
                  resultValid <= 1'b1;
                end
              end else begin
                sck_q  <= 1'b0;
                fall_q <= fall_q + 5'h01;
              end
            end else begin
              sck_q <= 1'b1;
              if (fall_q <= 5'(FRAME_BITS)) begin
                shift_q <= {shift_q[FRAME_BITS-2:0], sdo};
              end
            end
          end
        end
        HS_QUIET: begin
          if (gap_q == '0) begin
            state_q <= HS_IDLE;
          end else begin
            gap_q <= gap_q - 8'h01;
          end
        end
        default: begin
          csN_q   <= 1'b1;
          state_q <= HS_IDLE;
        end
      endcase
    end
  end

  assign busy             = (state_q != HS_IDLE);
  assign link.chipSelectN = csN_q;
  assign link.serialClock = sck_q;
endmodule

// file: bench/sarsr_link_properties.sv
// link pin assertions for the serial converter readout
`timescale 1ns/1ps
module sarsr_link_properties (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // link pins
  input wire logic chipSelectN,
  input wire logic serialClock,
  input wire logic serialResultOut,
  input wire logic serialResultOeN
);
  // ******
  // edge tracking
  // ******
  logic       sclk_q;
  logic [4:0] falls_q;
  logic [2:0] since_q;
  wire        sclkFell = sclk_q & ~serialClock;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  always_ff @(posedge ref_clk) sclk_q <= serialClock;
  always_ff @(posedge ref_clk) begin
    if (reset || chipSelectN) falls_q <= 5'h00;
    else if (sclkFell && falls_q != 5'h1f) falls_q <= falls_q + 5'h01;
  end
  // saturates so a long idle never looks like a recent fall
  always_ff @(posedge ref_clk) begin
    if (reset) since_q <= 3'h7;
    else if (sclkFell) since_q <= 3'h0;
    else if (since_q != 3'h7) since_q <= since_q + 3'h1;
  end
  a_idle_floats: assert property (chipSelectN [*6] |-> serialResultOeN)
    else $error("output driven while select high");
  a_fall_drives: assert property ($fell(chipSelectN) |-> ##[1:6] (!serialResultOeN || chipSelectN))
    else $error("select fall did not drive the output");
  a_drive_cause: assert property ($fell(serialResultOeN) |-> !chipSelectN && !$past(chipSelectN, 2))
    else $error("output driven without a select fall");
  a_first_zero: assert property ($fell(serialResultOeN) |-> !serialResultOut)
    else $error("first frame bit not zero");
  a_lead_zeros: assert property (!serialResultOeN && !chipSelectN && falls_q <= 5'd3 |-> !serialResultOut)
    else $error("leading bit not zero");
  a_float_sixteen: assert property (falls_q == 5'd16 |-> ##[0:6] serialResultOeN)
    else $error("output still driven after sixteenth fall");
  a_abort_floats: assert property ($rose(chipSelectN) |-> ##[1:6] serialResultOeN)
    else $error("output still driven after select rise");
  a_change_on_fall: assert property (!serialResultOeN && !$past(serialResultOeN) && $changed(serialResultOut)
    |-> since_q <= 3'd6)
    else $error("output changed away from a clock fall");
  a_quiet_gap: assert property ($fell(chipSelectN) |-> $past(serialResultOeN, 3))
    else $error("select fell inside the quiet time");
endmodule

// file: bench/sar_adc_serial_readout_tb.sv
// self-checking bench for the converter readout link
`timescale 1ns/1ps
module sar_adc_serial_readout_tb;
  logic        ref_clk;
  logic        reset;
  logic        startReq;
  logic [4:0]  clocksReq;
  logic [11:0] sampleIn;
  logic        busy;
  logic        poweredDown;
  logic        trackMode;
  logic        readyValid;
  logic        resultValid;
  logic [11:0] resultData;
  logic [9:0]  resultData10;
  int          miscompares;
  int          totalChecks;
  sarsr_if link ();
  sarsr_device sarsr_device_inst (.ref_clk(ref_clk), .reset(reset), .link(link.device), .sampleIn(sampleIn),
    .poweredDown(poweredDown), .trackMode(trackMode), .readyValid(readyValid));
  sarsr_host sarsr_host_inst (.ref_clk(ref_clk), .reset(reset), .link(link.host), .startReq(startReq),
    .clocksReq(clocksReq), .busy(busy), .resultData(resultData), .resultValid(resultValid));
  sarsr_link_properties sarsr_link_properties_inst (.ref_clk(ref_clk), .reset(reset),
    .chipSelectN(link.chipSelectN), .serialClock(link.serialClock), .serialResultOut(link.serialResultOut),
    .serialResultOeN(link.serialResultOeN));
  // ten-bit pair runs in lockstep with the main pair on the same requests
  sarsr_if link10 ();
  if (1'b1) begin : tenBit
    sarsr_device #(.RES_BITS(10)) sarsr_device_inst (.ref_clk(ref_clk), .reset(reset), .link(link10.device),
      .sampleIn(sampleIn[9:0]), .poweredDown(), .trackMode(), .readyValid());
    sarsr_host #(.RES_BITS(10)) sarsr_host_inst (.ref_clk(ref_clk), .reset(reset), .link(link10.host),
      .startReq(startReq), .clocksReq(clocksReq), .busy(), .resultData(resultData10), .resultValid());
  end
  // ******
  // checking and frames
  // ******
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    totalChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // bits are caught at each clock fall, before the device moves on to the next one
  task automatic conv(input string name, input logic [4:0] n, input logic [11:0] smp, input logic full,
                      input logic down);
    logic [15:0] frame;
    logic [15:0] frame10;
    logic        got;
    logic        prev;
    int          falls;
    int          t;
    frame = 16'h0000;
    frame10 = 16'h0000;
    got = 1'b0;
    falls = 0;
    t = 0;
    sampleIn = smp;
    clocksReq = n;
    startReq = 1'b1;
    @(negedge ref_clk);
    startReq = 1'b0;
    prev = link.serialClock;
    while (busy !== 1'b0 && t < 2000) begin
      @(negedge ref_clk);
      t++;
      if (resultValid === 1'b1) got = 1'b1;
      if (prev === 1'b1 && link.serialClock === 1'b0) begin
        falls++;
        if (falls <= 16) frame = {frame[14:0], link.serialResultOut};
        if (falls <= 16) frame10 = {frame10[14:0], link10.serialResultOut};
        if (falls == 13 && full) check("trackMode", 16'h0000, 16'(trackMode));
      end
      prev = link.serialClock;
    end
    check("timeout", 16'h0000, 16'(t >= 2000));
    if (t >= 2000) summarize();
    check("resultValid", 16'(full), 16'(got));
    check("poweredDown", 16'(down), 16'(poweredDown));
    check("oeN idle", 16'h0001, 16'(link.serialResultOeN));
    if (full) begin
      check("frame", {4'h0, smp}, frame);
      check("frame10", {4'h0, smp[9:0], 2'b00}, frame10);
      check("resultData10", 16'(smp[9:0]), 16'(resultData10));
      check("resultData", 16'(smp), 16'(resultData));
      check("trackMode", 16'h0001, 16'(trackMode));
    end
    $display("test %s done", name);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    reset = 1'b1;
    startReq = 1'b0;
    clocksReq = 5'h00;
    sampleIn = 12'h000;
    miscompares = 0;
    totalChecks = 0;
    repeat (3) @(negedge ref_clk);
    reset = 1'b0;
    conv("full", 5'h10, 12'h5a3, 1'b1, 1'b0);
    conv("long burst", 5'h12, 12'h801, 1'b1, 1'b0);
    conv("glitch", 5'h01, 12'h000, 1'b0, 1'b0);
    conv("stay up", 5'h0a, 12'h000, 1'b0, 1'b0);
    conv("sleep", 5'h02, 12'h000, 1'b0, 1'b1);
    conv("sleep glitch", 5'h01, 12'h000, 1'b0, 1'b1);
    conv("short wake", 5'h09, 12'h000, 1'b0, 1'b1);
    conv("wake", 5'h0a, 12'h000, 1'b0, 1'b0);
    check("readyValid low", 16'h0000, 16'(readyValid));
    for (int i = 0; i < 60 && readyValid !== 1'b1; i++) @(negedge ref_clk);
    check("readyValid", 16'h0001, 16'(readyValid));
    conv("after wake", 5'h10, 12'h7ff, 1'b1, 1'b0);
    conv("back to back", 5'h10, 12'h000, 1'b1, 1'b0);
    summarize();
  end
endmodule
